// ### include/acs_pkg.sv
// Shared constants, types and register map of the conversion sequencer
package acs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ACS_OFS_CONTROL_0 = 8'h00;
  localparam logic [7:0] ACS_OFS_CONTROL_1 = 8'h04;
  localparam logic [7:0] ACS_OFS_RESULT_HIGH = 8'h08;
  localparam logic [7:0] ACS_OFS_RESULT_LOW = 8'h0c;
  localparam logic [7:0] ACS_OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ACS_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] ACS_OFS_GLOBAL_IRQ = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACS_C0_CHAN_LSB = 0;
  localparam int ACS_C0_FORMAT_BIT = 4;
  localparam int ACS_C0_POWER_BIT = 5;
  localparam int ACS_C0_BUSY_BIT = 6;
  localparam int ACS_C0_START_BIT = 7;
  localparam int ACS_C1_SRC_LSB = 0;
  localparam int ACS_C1_DIV_LSB = 4;
  localparam int ACS_C1_REF_LSB = 8;
  localparam int ACS_C1_GAIN_LSB = 10;
  localparam int ACS_C1_PGA_IN_LSB = 13;
  localparam int ACS_IRQ_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // Codes, reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [3:0] ACS_SRC_EXTERNAL_A = 4'h0;
  localparam logic [3:0] ACS_SRC_EXTERNAL_B = 4'h4;
  localparam logic [3:0] ACS_CHAN_LAST = 4'hb;
  localparam logic [1:0] ACS_REF_AMPLIFIED = 2'h1;
  localparam logic [3:0] ACS_SAMPLE_TICKS = 4'h4;
  localparam logic [3:0] ACS_CONVERT_TICKS = 4'hc;
  localparam logic [11:0] ACS_SAR_FIRST_TRIAL = 12'h800;
  localparam logic [11:0] ACS_RESULT_RESET = 12'h000;
  localparam logic [2:0] ACS_DIV_RESET = 3'h0;
  localparam logic [31:0] ACS_READ_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_SAMPLE,
    ACS_CONVERT
  } acs_seq_t;

  // Everything the analog core needs from the sequencer
  typedef struct packed {
    logic power_on;
    logic sample_hold;
    logic [11:0] trial_code;
    logic ext_connect;
    logic [3:0] ext_channel;
    logic [3:0] internal_source;
    logic [1:0] reference_source;
    logic pga_active;
    logic [1:0] pga_input;
    logic [2:0] pga_gain;
  } acs_analog_t;

endpackage

// ### design/acs_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
module acs_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);
  import acs_pkg::*;

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } acs_sync_state_t;

  acs_sync_state_t state;
  acs_sync_state_t next_state;

  // The first stage feeds only the second; the level moves once stages two and three agree
  always_comb begin
    next_state = state;
    next_state.stage = {state.stage[1:0], async_in};
    if (state.stage[1] == state.stage[2]) begin
      next_state.level = state.stage[2];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Agreement is passed on in the cycle it appears, so a decision costs three clocks, not four
  assign sync_out = (state.stage[1] == state.stage[2]) ? state.stage[2] : state.level;
endmodule // acs_sync

// ### design/acs_clk_div.sv
// Converter clock tick generator: one tick every 2**div system clocks
`timescale 1ns/1ps
module acs_clk_div #(
  parameter int DIV_W = 3,
  parameter int CNT_W = 7
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);
  import acs_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } acs_div_state_t;

  acs_div_state_t state;
  acs_div_state_t next_state;
  logic [CNT_W-1:0] period_mask;

  // Code 000 ticks every clock, code 111 every 128 clocks
  always_comb begin
    period_mask = CNT_W'((1 << div) - 1);
    tick = (state.count & period_mask) == period_mask;
    next_state.count = restart ? '0 : CNT_W'(state.count + 1'b1);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule // acs_clk_div

// ### design/acs_sequencer.sv
// Conversion sequencer: Avalon-MM registers, start detect, SAR timing, result and interrupt
`timescale 1ns/1ps
module acs_sequencer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comparator_in,
  output acs_pkg::acs_analog_t analog,
  output logic conversion_busy_flag,
  output logic irq
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    acs_seq_t seq;
    logic [3:0] phase;
    logic [11:0] code;
    logic [11:0] result;
    logic busy;
    logic start_bit;
    logic converter_power_enable;
    logic result_format_select;
    logic [3:0] external_channel_select;
    logic [3:0] input_source_select;
    logic [2:0] converter_clock_divider;
    logic [1:0] reference_source_select;
    logic [2:0] pga_gain;
    logic [1:0] pga_input;
    logic converter_irq_flag;
    logic converter_irq_enable;
    logic global_interrupt_enable;
    logic ack;
    logic [31:0] rdata;
  } acs_state_t;

  acs_state_t state;
  acs_state_t next_state;

  logic conv_tick;
  logic cmp_level;
  logic divider_restart;
  logic start_rise;
  logic start_fall;
  logic bus_req;
  logic wr_take;
  logic rd_take;
  logic [15:0] wmask;
  logic [15:0] wdata16;
  logic [15:0] ctrl0_word;
  logic [15:0] ctrl1_word;
  logic [15:0] new_c0;
  logic [15:0] new_c1;
  logic [31:0] read_word;
  logic irq_set;
  logic irq_clear;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic [11:0] trial_bit;
  logic [11:0] kept_code;
  logic done_event;
  logic ext_source;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  acs_clk_div #(
    .DIV_W(3),
    .CNT_W(7)
  ) u_clk_div (
    .clk(clk),
    .rst_b(rst_b),
    .restart(divider_restart),
    .div(state.converter_clock_divider),
    .tick(conv_tick)
  );

  // Comparator decisions lag by a few system clocks; slow divider codes leave margin
  acs_sync u_cmp_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(comparator_in),
    .sync_out(cmp_level)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait cycle per access: request seen, then answered on the next edge
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~state.ack;
  assign wr_take = avs_write & state.ack;
  assign rd_take = avs_read & ~state.ack;
  assign avs_readdata = state.rdata;
  assign wdata16 = avs_writedata[15:0];
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  always_comb begin
    ctrl0_word = '0;
    ctrl0_word[ACS_C0_CHAN_LSB +: 4] = state.external_channel_select;
    ctrl0_word[ACS_C0_FORMAT_BIT] = state.result_format_select;
    ctrl0_word[ACS_C0_POWER_BIT] = state.converter_power_enable;
    ctrl0_word[ACS_C0_BUSY_BIT] = state.busy;
    ctrl0_word[ACS_C0_START_BIT] = state.start_bit;
    ctrl1_word = '0;
    ctrl1_word[ACS_C1_SRC_LSB +: 4] = state.input_source_select;
    ctrl1_word[ACS_C1_DIV_LSB +: 3] = state.converter_clock_divider;
    ctrl1_word[ACS_C1_REF_LSB +: 2] = state.reference_source_select;
    ctrl1_word[ACS_C1_GAIN_LSB +: 3] = state.pga_gain;
    ctrl1_word[ACS_C1_PGA_IN_LSB +: 2] = state.pga_input;
  end

  // Words a control write leaves behind; the busy bit is never taken from them
  assign new_c0 = (ctrl0_word & ~wmask) | (wdata16 & wmask);
  assign new_c1 = (ctrl1_word & ~wmask) | (wdata16 & wmask);

  // Alignment is applied on read, so the stored code never depends on the format bit
  always_comb begin
    if (state.result_format_select) begin
      result_high_byte = {4'h0, state.result[11:8]};
      result_low_byte = state.result[7:0];
    end else begin
      result_high_byte = state.result[11:4];
      result_low_byte = {state.result[3:0], 4'h0};
    end
  end

  // ----------------------------------------------------------------
  // Start pulse detection
  // ----------------------------------------------------------------
  always_comb begin
    start_rise = 1'b0;
    start_fall = 1'b0;
    if (wr_take && avs_address == ACS_OFS_CONTROL_0) begin
      start_rise = ~state.start_bit & new_c0[ACS_C0_START_BIT];
      start_fall = state.start_bit & ~new_c0[ACS_C0_START_BIT];
    end
  end

  // Converter clock phase restarts with each new conversion
  assign divider_restart = start_fall;

  // ----------------------------------------------------------------
  // Successive approximation step
  // ----------------------------------------------------------------
  always_comb begin
    trial_bit = ACS_SAR_FIRST_TRIAL >> state.phase;
    // Comparator high means the input lies at or above the trial code
    kept_code = cmp_level ? state.code : (state.code & ~trial_bit);
  end

  assign done_event = (state.seq == ACS_CONVERT) && conv_tick
    && (state.phase == ACS_CONVERT_TICKS - 4'h1);

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  always_comb begin
    case (avs_address)
      ACS_OFS_CONTROL_0: read_word = {16'h0000, ctrl0_word};
      ACS_OFS_CONTROL_1: read_word = {16'h0000, ctrl1_word};
      ACS_OFS_RESULT_HIGH: read_word = {24'h000000, result_high_byte};
      ACS_OFS_RESULT_LOW: read_word = {24'h000000, result_low_byte};
      ACS_OFS_IRQ_STATUS: read_word = {31'h0, state.converter_irq_flag};
      ACS_OFS_IRQ_MASK: read_word = {31'h0, state.converter_irq_enable};
      ACS_OFS_GLOBAL_IRQ: read_word = {31'h0, state.global_interrupt_enable};
      default: read_word = ACS_READ_UNMAPPED;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  assign irq_clear = wr_take && (avs_address == ACS_OFS_IRQ_STATUS) && avs_byteenable[0]
    && avs_writedata[ACS_IRQ_DONE_BIT];
  // A start rise in the completing cycle raises no flag, though the result is still stored
  assign irq_set = done_event && state.converter_power_enable && !start_rise;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    // A request still held after its answer starts a new access
    next_state.ack = bus_req & ~state.ack;

    // Read data is captured on the first cycle of a read
    if (rd_take) begin
      next_state.rdata = read_word;
    end

    // Register writes
    if (wr_take) begin
      case (avs_address)
        ACS_OFS_CONTROL_0: begin
          next_state.external_channel_select = new_c0[ACS_C0_CHAN_LSB +: 4];
          next_state.result_format_select = new_c0[ACS_C0_FORMAT_BIT];
          next_state.converter_power_enable = new_c0[ACS_C0_POWER_BIT];
          next_state.start_bit = new_c0[ACS_C0_START_BIT];
        end
        ACS_OFS_CONTROL_1: begin
          next_state.input_source_select = new_c1[ACS_C1_SRC_LSB +: 4];
          next_state.converter_clock_divider = new_c1[ACS_C1_DIV_LSB +: 3];
          next_state.reference_source_select = new_c1[ACS_C1_REF_LSB +: 2];
          next_state.pga_gain = new_c1[ACS_C1_GAIN_LSB +: 3];
          next_state.pga_input = new_c1[ACS_C1_PGA_IN_LSB +: 2];
        end
        ACS_OFS_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            next_state.converter_irq_enable = avs_writedata[0];
          end
        end
        ACS_OFS_GLOBAL_IRQ: begin
          if (avs_byteenable[0]) begin
            next_state.global_interrupt_enable = avs_writedata[0];
          end
        end
        default: begin
        end
      endcase
    end

    // Sequencer runs on its own once started, with no further bus traffic
    case (state.seq)
      ACS_IDLE: begin
        next_state.phase = '0;
      end
      ACS_SAMPLE: begin
        if (conv_tick) begin
          if (state.phase == ACS_SAMPLE_TICKS - 4'h1) begin
            next_state.seq = ACS_CONVERT;
            next_state.phase = '0;
            next_state.code = ACS_SAR_FIRST_TRIAL;
          end else begin
            next_state.phase = state.phase + 4'h1;
          end
        end
      end
      ACS_CONVERT: begin
        if (conv_tick) begin
          next_state.code = kept_code | (trial_bit >> 1);
          if (done_event) begin
            next_state.seq = ACS_IDLE;
            next_state.phase = '0;
            next_state.busy = 1'b0;
            next_state.result = kept_code;
          end else begin
            next_state.phase = state.phase + 4'h1;
          end
        end
      end
      default: begin
        next_state.seq = ACS_IDLE;
        next_state.phase = '0;
      end
    endcase

    // A new rising edge abandons any conversion; the falling edge begins sampling
    if (start_rise) begin
      next_state.seq = ACS_IDLE;
      next_state.busy = 1'b0;
      next_state.phase = '0;
    end
    if (start_fall && state.converter_power_enable) begin
      next_state.seq = ACS_SAMPLE;
      next_state.phase = '0;
      next_state.busy = 1'b1;
    end

    // Powered down: nothing runs, and a conversion in flight is lost
    if (!next_state.converter_power_enable) begin
      next_state.seq = ACS_IDLE;
      next_state.busy = 1'b0;
      next_state.phase = '0;
    end

    // Completion wins over a simultaneous write-one-to-clear
    if (irq_clear) begin
      next_state.converter_irq_flag = 1'b0;
    end
    if (irq_set) begin
      next_state.converter_irq_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
      state.seq <= ACS_IDLE;
      state.result <= ACS_RESULT_RESET;
      state.converter_clock_divider <= ACS_DIV_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the analog core
  // ----------------------------------------------------------------
  assign ext_source = (state.input_source_select == ACS_SRC_EXTERNAL_A)
    || (state.input_source_select == ACS_SRC_EXTERNAL_B);

  always_comb begin
    analog = '0;
    analog.power_on = state.converter_power_enable;
    if (state.converter_power_enable) begin
      analog.sample_hold = state.seq == ACS_SAMPLE;
      analog.trial_code = (state.seq == ACS_CONVERT) ? state.code : '0;
      // Channel codes past the last one leave the input floating
      analog.ext_connect = ext_source
        && (state.external_channel_select <= ACS_CHAN_LAST);
      analog.ext_channel = analog.ext_connect ? state.external_channel_select : '0;
      analog.internal_source = state.input_source_select;
      analog.reference_source = state.reference_source_select;
      analog.pga_active = state.reference_source_select == ACS_REF_AMPLIFIED;
      analog.pga_input = analog.pga_active ? state.pga_input : '0;
      analog.pga_gain = analog.pga_active ? state.pga_gain : '0;
    end
  end

  assign conversion_busy_flag = state.busy;

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  assign irq = state.converter_irq_flag & state.converter_irq_enable
    & state.global_interrupt_enable;
endmodule // acs_sequencer

// ### testbench/acs_sequencer_checker.sv
// Port-level property checker for the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic comparator_in,
  input wire acs_pkg::acs_analog_t analog,
  input wire logic conversion_busy_flag,
  input wire logic irq
);
  import acs_pkg::*;
  logic [11:0] cnt_b;
  logic [11:0] cnt_s;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Busy and sampling cycles of the running conversion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_b <= 12'h000;
      cnt_s <= 12'h000;
    end else if (!conversion_busy_flag) begin
      cnt_b <= 12'h000;
      cnt_s <= 12'h000;
    end else begin
      cnt_b <= cnt_b + 12'h001;
      cnt_s <= cnt_s + {11'h000, analog.sample_hold};
    end
  end
  busy_start_cause_a: assert property ($rose(conversion_busy_flag) |->
    $past(avs_write && !avs_waitrequest && avs_address == ACS_OFS_CONTROL_0
    && avs_writedata[ACS_C0_POWER_BIT] && !avs_writedata[ACS_C0_START_BIT]))
    else $error("busy rose without a start write");
  // Writes may abort, so only undisturbed conversions are timed
  conv_length_a: assert property ($fell(conversion_busy_flag) && !$past(avs_write)
    && !$past(avs_write, 2) |-> cnt_b == {cnt_s[9:0], 2'b00} && cnt_s >= 12'h004
    && (cnt_s & (cnt_s - 12'h001)) == 12'h000)
    else $error("conversion length wrong");
  first_trial_a: assert property ($fell(analog.sample_hold) && conversion_busy_flag
    && !$past(avs_write) |-> analog.trial_code == ACS_SAR_FIRST_TRIAL)
    else $error("conversion did not start after sampling");
  idle_quiet_a: assert property (!conversion_busy_flag |->
    !analog.sample_hold && analog.trial_code == 12'h000)
    else $error("converter active while not busy");
  power_down_a: assert property (!analog.power_on |-> analog == '0)
    else $error("analog controls active while powered down");
  internal_cut_a: assert property (analog.internal_source != ACS_SRC_EXTERNAL_A
    && analog.internal_source != ACS_SRC_EXTERNAL_B |-> !analog.ext_connect)
    else $error("external channel connected with internal source");
  pga_apply_a: assert property (analog.pga_active ==
    (analog.reference_source == ACS_REF_AMPLIFIED && analog.power_on)
    && (analog.pga_active || (analog.pga_gain == 3'h0 && analog.pga_input == 2'h0)))
    else $error("amplifier settings wrong for reference");
  irq_cause_a: assert property ($rose(irq) |-> $fell(conversion_busy_flag)
    || $past(avs_write && !avs_waitrequest))
    else $error("interrupt rose without completion or enable write");
  busy_hold_a: assert property (conversion_busy_flag && !avs_write
    && cnt_s < 12'h003 |=> conversion_busy_flag)
    else $error("busy dropped early without software action");
endmodule // acs_sequencer_checker

bind acs_sequencer acs_sequencer_checker acs_sequencer_checker_inst (
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .comparator_in(comparator_in), .analog(analog),
  .conversion_busy_flag(conversion_busy_flag), .irq(irq)
);

// ### testbench/acs_analog_model.sv
// Behavioural analog core: sample-and-hold and ideal comparator
`timescale 1ns/1ps
module acs_analog_model (
  input wire logic clk,
  input wire acs_pkg::acs_analog_t analog,
  input wire logic [11:0] ext_level,
  input wire logic [11:0] int_level,
  output logic comparator_in
);
  import acs_pkg::*;
  logic [11:0] held = 12'h000;
  logic wiggle = 1'b0;
  // Outside a trial the output toggles while powered on (and stays low when powered down), so no stale decision can pass
  always_ff @(posedge clk) begin
    wiggle <= ~wiggle;
    if (analog.sample_hold) begin
      held <= analog.ext_connect ? ext_level : int_level;
    end
  end
  always_comb begin
    if (!analog.power_on) begin
      comparator_in = 1'b0;
    end else if (analog.trial_code == 12'h000) begin
      comparator_in = wiggle;
    end else begin
      comparator_in = held >= analog.trial_code;
    end
  end
endmodule // acs_analog_model

// ### testbench/test_adc_conversion_sequencer.sv
// Self-checking bench: random and corner conversions over the register bus
`timescale 1ns/1ps
module test_adc_conversion_sequencer;
  import acs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic comparator_in;
  acs_analog_t analog;
  logic conversion_busy_flag;
  logic irq;
  logic [11:0] ext_level = 12'h000;
  logic [11:0] int_level = 12'h000;
  logic [31:0] lfsr = 32'hd4ff;
  logic [31:0] rd = 32'h0;
  logic [11:0] last_res = ACS_RESULT_RESET;
  int fails = 0;
  int check_count = 0;

  acs_sequencer acs_sequencer_inst (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .comparator_in(comparator_in), .analog(analog),
    .conversion_busy_flag(conversion_busy_flag), .irq(irq)
  );
  acs_analog_model acs_analog_model_inst (
    .clk(clk), .analog(analog), .ext_level(ext_level), .int_level(int_level),
    .comparator_in(comparator_in)
  );

  initial begin
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] fmt_byte(input logic [11:0] r, input logic f, input logic hi);
    if (hi) begin
      return f ? {28'h0, r[11:8]} : {24'h0, r[11:4]};
    end
    return f ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0};
  endfunction

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Called just after a rising edge; returns just after the edge following release
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    logic w;
    int n;
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    w = 1'b1;
    n = 0;
    while (w !== 1'b0 && n < 20) begin
      @(posedge clk);
      w = avs_waitrequest;
      rd = avs_readdata;
      n++;
    end
    if (w !== 1'b0) begin
      fails++;
      finish_test();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0);
    check(what, exp, rd);
  endtask

  task automatic convert(input logic [11:0] lvl, input logic [2:0] div, input logic fmt,
                         input logic [3:0] chan, input logic [3:0] src, input logic ie,
                         input logic abort);
    int n;
    logic ext;
    logic [31:0] c0;
    ext = (src == ACS_SRC_EXTERNAL_A || src == ACS_SRC_EXTERNAL_B);
    c0 = {26'h0, 1'b1, fmt, chan};
    ext_level <= ext ? lvl : ~lvl;
    int_level <= ext ? ~lvl : lvl;
    lfsr = next_rand(lfsr);
    bus(1'b1, ACS_OFS_CONTROL_1, {17'h0, lfsr[14:8], 1'b0, div, src});
    bus(1'b1, ACS_OFS_CONTROL_0, c0);
    repeat (8) @(posedge clk);
    bus(1'b1, ACS_OFS_IRQ_MASK, {31'h0, ie});
    bus(1'b1, ACS_OFS_GLOBAL_IRQ, 32'h1);
    bus(1'b1, ACS_OFS_CONTROL_0, c0 | 32'h80);
    bus(1'b1, ACS_OFS_CONTROL_0, c0);
    if (abort) begin
      repeat (3) @(posedge clk);
      bus(1'b1, ACS_OFS_CONTROL_0, c0 | 32'h80);
      @(negedge clk);
      check("busy_abort", 32'h0, {31'h0, conversion_busy_flag});
      @(posedge clk);
      rdchk(ACS_OFS_RESULT_HIGH, fmt_byte(last_res, fmt, 1'b1), "held_high");
      bus(1'b1, ACS_OFS_CONTROL_0, c0);
    end
    n = 1;
    @(negedge clk);
    check("busy_rise", 32'h1, {31'h0, conversion_busy_flag});
    check("ext_connect", {31'h0, ext}, {31'h0, analog.ext_connect});
    while (conversion_busy_flag === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end
    if (n >= 5000) begin
      fails++;
      finish_test();
    end
    check("busy_cycles", 32'd16 << div, n);
    check("irq", {31'h0, ie}, {31'h0, irq});
    last_res = lvl;
    @(posedge clk);
    rdchk(ACS_OFS_RESULT_HIGH, fmt_byte(lvl, fmt, 1'b1), "result_high");
    rdchk(ACS_OFS_RESULT_LOW, fmt_byte(lvl, fmt, 1'b0), "result_low");
    rdchk(ACS_OFS_IRQ_STATUS, 32'h1, "irq_flag");
    bus(1'b1, ACS_OFS_IRQ_STATUS, 32'h1);
    @(negedge clk);
    check("irq_clear", 32'h0, {31'h0, irq});
    @(posedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("busy_reset", 32'h0, {31'h0, conversion_busy_flag});
    @(posedge clk);
    rdchk(ACS_OFS_RESULT_LOW, 32'h0, "result_reset");
    rdchk(8'h1c, ACS_READ_UNMAPPED, "unmapped");
    convert(12'hfff, 3'h2, 1'b0, 4'h0, ACS_SRC_EXTERNAL_A, 1'b1, 1'b0);
    convert(12'h001, 3'h3, 1'b1, ACS_CHAN_LAST, ACS_SRC_EXTERNAL_B, 1'b0, 1'b1);
    convert(12'h000, 3'h3, 1'b0, 4'h2, 4'h5, 1'b1, 1'b1);
    for (int i = 0; i < 12; i++) begin
      repeat (16) lfsr = next_rand(lfsr);
      convert(lfsr[11:0], {2'b01, lfsr[12]}, lfsr[13], {1'b0, lfsr[16:14]}, lfsr[20:17],
              lfsr[21], lfsr[22]);
    end
    bus(1'b1, ACS_OFS_CONTROL_0, 32'ha0);
    bus(1'b1, ACS_OFS_CONTROL_0, 32'h20);
    @(negedge clk);
    check("busy_on", 32'h1, {31'h0, conversion_busy_flag});
    repeat (3) @(posedge clk);
    bus(1'b1, ACS_OFS_CONTROL_0, 32'h00);
    @(negedge clk);
    check("busy_off", 32'h0, {31'h0, conversion_busy_flag});
    check("power_on", 32'h0, {31'h0, analog.power_on});
    @(posedge clk);
    bus(1'b1, ACS_OFS_CONTROL_0, 32'h80);
    bus(1'b1, ACS_OFS_CONTROL_0, 32'h00);
    @(negedge clk);
    check("busy_refused", 32'h0, {31'h0, conversion_busy_flag});
    @(posedge clk);
    rdchk(ACS_OFS_IRQ_STATUS, 32'h0, "flag_off");
    finish_test();
  end
endmodule // test_adc_conversion_sequencer
